//--- design/spc_port.sv
// Purpose: serial peripheral port, master or slave, with a Wishbone register slave
// Assumes: one clock clk_in, synchronous active-high reset, far end holds data a half period
// Notes:   pins sampled through three flops; a change counts once stages two and three agree
`timescale 1ns/1ps
module spc_port #(
  parameter int HALF_BASE = spc_pkg::HALF_BASE
) (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [3:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  input  wire logic        sclk_in,
  output logic             sclk_out,
  output logic             sclk_oe_out,
  input  wire logic        mosi_in,
  output logic             mosi_out,
  output logic             mosi_oe_out,
  input  wire logic        miso_in,
  output logic             miso_out,
  output logic             miso_oe_out,
  input  wire logic        sel_n_in
);
  logic [7:0]  control_r;
  logic [7:0]  data_r;
  logic        ack_r;
  logic [31:0] rdat_r;
  logic        sclk_r;
  logic        sclk_oe_r;
  logic        mosi_oe_r;
  logic        miso_oe_r;
  logic        dout_r;
  logic        rx_latch_r;
  logic        half_r;
  logic [3:0]  bitcnt_r;
  logic [5:0]  div_r;
  logic        done_r;
  spc_pkg::spc_state_e state_r;
  logic [spc_pkg::PIN_COUNT-1:0] pin_raw;
  logic [spc_pkg::PIN_COUNT-1:0] pin_f;

  // half period in clocks for the two-bit rate field
  function automatic logic [5:0] half_of(input logic [1:0] sel);
    half_of = 6'(HALF_BASE << sel);
  endfunction

  // synchronisers: stage one feeds stage two only
  assign pin_raw = {sel_n_in, miso_in, mosi_in, sclk_in};
  genvar g;
  generate
    for (g = 0; g < spc_pkg::PIN_COUNT; g++) begin : g_sync
      logic [spc_pkg::SYNC_DEPTH-1:0] st_r;
      logic                           flt_r;
      always_ff @(posedge clk_in) begin
        // the select pin rests high; resetting its stages low would fake a select right after reset
        if (rst_in) begin
          st_r  <= (g == spc_pkg::PIN_SEL_N) ? '1 : '0;
          flt_r <= (g == spc_pkg::PIN_SEL_N);
        end else begin
          st_r <= {st_r[spc_pkg::SYNC_DEPTH-2:0], pin_raw[g]};
          if (st_r[1] == st_r[2]) begin
            flt_r <= st_r[2];
          end
        end
      end
      // agreeing stages pass straight through, so a four-clock half period still sees the new level
      assign pin_f[g] = (st_r[1] == st_r[2]) ? st_r[2] : flt_r;
    end
  endgenerate

  logic enabled;
  logic master;
  logic cpol;
  logic cpha;
  logic req;
  logic wr_fire;
  logic wr_ctrl;
  logic wr_data;
  logic busy;
  logic slave_sel;
  logic sclk_f_d_r;
  logic lead;
  logic trail;
  logic tick;
  logic din;
  assign enabled   = !control_r[spc_pkg::BIT_DISABLE];
  assign master    = control_r[spc_pkg::BIT_MASTER];
  assign cpol      = control_r[spc_pkg::BIT_CPOL];
  assign cpha      = control_r[spc_pkg::BIT_CPHA];
  assign req       = wb_cyc_in && wb_stb_in;
  assign wr_fire   = req && wb_we_in && ack_r && wb_sel_in[0];
  assign wr_ctrl   = wr_fire && (wb_adr_in == spc_pkg::ADDR_CONTROL);
  assign wr_data   = wr_fire && (wb_adr_in == spc_pkg::ADDR_DATA);
  assign busy      = (state_r == spc_pkg::SPC_SHIFT);
  assign slave_sel = enabled && !master && !pin_f[spc_pkg::PIN_SEL_N];
  assign tick      = busy && master && (div_r == 6'h00);
  // edges: away from the rest level is leading, back to it is trailing
  assign lead  = master ? (tick && !half_r)
                        : (slave_sel && (pin_f[spc_pkg::PIN_SCLK] != sclk_f_d_r)
                           && (pin_f[spc_pkg::PIN_SCLK] != cpol));
  assign trail = master ? (tick && half_r)
                        : (slave_sel && (pin_f[spc_pkg::PIN_SCLK] != sclk_f_d_r)
                           && (pin_f[spc_pkg::PIN_SCLK] == cpol));
  assign din   = master ? pin_f[spc_pkg::PIN_MISO] : pin_f[spc_pkg::PIN_MOSI];

  // wishbone: ack one cycle after request, dropped the cycle after
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ack_r  <= 1'b0;
      rdat_r <= '0;
    end else begin
      ack_r <= req && !ack_r;
      unique case (wb_adr_in)
        spc_pkg::ADDR_CONTROL: rdat_r <= {24'h000000, control_r};
        spc_pkg::ADDR_DATA:    rdat_r <= {24'h000000, data_r};
        default:               rdat_r <= 32'h00000000;
      endcase
    end
  end

  // control: flags set by hardware win over a clearing write
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      control_r <= spc_pkg::CONTROL_RESET;
    end else begin
      if (wr_ctrl) begin
        control_r[5:0] <= wb_dat_in[5:0] & spc_pkg::CONTROL_WMASK[5:0];
      end
      if (done_r) begin
        control_r[spc_pkg::BIT_DONE] <= 1'b1;
      end else if (wr_ctrl && !wb_dat_in[spc_pkg::BIT_DONE]) begin
        control_r[spc_pkg::BIT_DONE] <= 1'b0;
      end
      if (wr_data && busy) begin
        control_r[spc_pkg::BIT_WRITE_COLLISION_FLAG] <= 1'b1;
      end else if (wr_ctrl && !wb_dat_in[spc_pkg::BIT_WRITE_COLLISION_FLAG]) begin
        control_r[spc_pkg::BIT_WRITE_COLLISION_FLAG] <= 1'b0;
      end
    end
  end

  // transfer engine; a write during a transfer is dropped, not merged
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_r    <= spc_pkg::SPC_IDLE;
      data_r     <= spc_pkg::DATA_RESET;
      dout_r     <= 1'b0;
      rx_latch_r <= 1'b0;
      half_r     <= 1'b0;
      bitcnt_r   <= '0;
      div_r      <= '0;
      done_r     <= 1'b0;
      sclk_r     <= 1'b0;
      sclk_f_d_r <= 1'b0;
    end else begin
      done_r     <= 1'b0;
      sclk_f_d_r <= pin_f[spc_pkg::PIN_SCLK];
      if (!enabled || (!master && pin_f[spc_pkg::PIN_SEL_N] && busy)) begin
        state_r <= spc_pkg::SPC_IDLE;
        sclk_r  <= cpol;
      end else if (!busy) begin
        sclk_r   <= cpol;
        half_r   <= 1'b0;
        bitcnt_r <= '0;
        div_r    <= half_of(control_r[spc_pkg::BIT_RATE_HI:0]) - 6'd1;
        if (wr_data) begin
          data_r <= wb_dat_in[7:0];
          dout_r <= wb_dat_in[7];
          if (master) begin
            state_r <= spc_pkg::SPC_SHIFT;
          end
        end else if (slave_sel) begin
          state_r <= spc_pkg::SPC_SHIFT;
          dout_r  <= data_r[7];
        end
      end else begin
        if (master) begin
          if (tick) begin
            div_r  <= half_of(control_r[spc_pkg::BIT_RATE_HI:0]) - 6'd1;
            sclk_r <= !sclk_r;
            half_r <= !half_r;
          end else begin
            div_r <= div_r - 6'd1;
          end
        end
        if (lead) begin
          if (cpha) begin
            dout_r <= data_r[7];
          end else begin
            rx_latch_r <= din;
          end
        end
        if (trail) begin
          data_r   <= {data_r[6:0], cpha ? din : rx_latch_r};
          // leading-edge phase: the far end sampled at the leading edge, so the next bit goes out on the line now
          if (!cpha) begin
            dout_r <= data_r[6];
          end
          bitcnt_r <= bitcnt_r + 4'd1;
          if (bitcnt_r == 4'(spc_pkg::FRAME_BITS - 1)) begin
            state_r <= spc_pkg::SPC_IDLE;
            done_r  <= 1'b1;
          end
        end
      end
    end
  end

  // pin drivers: a slave drives only its data out, and only while selected
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sclk_oe_r <= 1'b0;
      mosi_oe_r <= 1'b0;
      miso_oe_r <= 1'b0;
    end else begin
      sclk_oe_r <= enabled && master;
      mosi_oe_r <= enabled && master;
      miso_oe_r <= slave_sel;
    end
  end

  assign wb_ack_out  = ack_r;
  assign wb_dat_out  = rdat_r;
  assign sclk_out    = sclk_r;
  assign sclk_oe_out = sclk_oe_r;
  assign mosi_out    = dout_r;
  assign mosi_oe_out = mosi_oe_r;
  assign miso_out    = dout_r;
  assign miso_oe_out = miso_oe_r;

  done_flag_a: assert property (@(posedge clk_in) disable iff (rst_in)
    done_r |=> control_r[spc_pkg::BIT_DONE])
    else $error("done flag not set after transfer");
  collision_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (wr_data && busy) |=> control_r[spc_pkg::BIT_WRITE_COLLISION_FLAG] && ($stable(data_r) || $past(trail)))
    else $error("collision not flagged or data overwritten");
  disable_idle_a: assert property (@(posedge clk_in) disable iff (rst_in)
    !enabled |=> !busy && !sclk_oe_out && !miso_oe_out)
    else $error("disabled port still active");
  slave_clock_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (!master && $past(!master)) |-> !sclk_oe_out)
    else $error("slave drives serial clock");
  rest_level_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (!busy && $past(!busy) && $stable(cpol)) |-> (sclk_r == cpol))
    else $error("serial clock not at rest level");
  phase_edge_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (bitcnt_r != $past(bitcnt_r) && $past(busy)) |-> $past(trail))
    else $error("bit counted off the trailing edge");
  rate_bound_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (busy && master) |-> (div_r < half_of(control_r[spc_pkg::BIT_RATE_HI:0])))
    else $error("divider beyond selected half period");
  master_start_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (wr_data && !busy && master && enabled) |=> busy && (data_r == $past(wb_dat_in[7:0])))
    else $error("master write did not start exchange");
  done_c: cover property (@(posedge clk_in) disable iff (rst_in) done_r && master);
  slave_done_c: cover property (@(posedge clk_in) disable iff (rst_in) done_r && !master);
  collision_c: cover property (@(posedge clk_in) disable iff (rst_in) wr_data && busy);
endmodule // spc_port

//--- pkg/spc_pkg.sv
// Purpose: constants for the serial peripheral port block
// Assumes: 32-bit classic Wishbone, byte addressed, one register per aligned word
// Notes:   flags in the control register are set by hardware, cleared by writing zero
package spc_pkg;
  localparam int          WB_AW          = 4;
  localparam logic [3:0]  ADDR_CONTROL   = 4'h0;
  localparam logic [3:0]  ADDR_DATA      = 4'h4;
  localparam int          BIT_DONE       = 7;
  localparam int          BIT_WRITE_COLLISION_FLAG       = 6;
  localparam int          BIT_DISABLE    = 5;
  localparam int          BIT_MASTER     = 4;
  localparam int          BIT_CPOL       = 3;
  localparam int          BIT_CPHA       = 2;
  localparam int          BIT_RATE_HI    = 1;
  localparam logic [7:0]  CONTROL_RESET  = 8'h00;
  localparam logic [7:0]  DATA_RESET     = 8'h00;
  localparam logic [7:0]  CONTROL_WMASK  = 8'h3F;
  localparam int          FRAME_BITS     = 8;
  localparam int          HALF_BASE      = 4;
  localparam int          SYNC_DEPTH     = 3;
  localparam int          PIN_COUNT      = 4;
  localparam int          PIN_SCLK       = 0;
  localparam int          PIN_MOSI       = 1;
  localparam int          PIN_MISO       = 2;
  localparam int          PIN_SEL_N      = 3;
  typedef enum logic [0:0] {SPC_IDLE, SPC_SHIFT} spc_state_e;
endpackage

//--- verif/spc_slave_model.sv
// Purpose: behavioural serial slave standing on the far side of the port in master mode
// Assumes: mode inputs are settled before load_in rises and stay put for the whole frame
// Notes:   shifted-out positions refill with changing bits so a stale line is not read as good data
`timescale 1ns/1ps
module spc_slave_model (
  input  wire logic       sclk_in,
  input  wire logic       mosi_in,
  input  wire logic       cpol_in,
  input  wire logic       cpha_in,
  input  wire logic       load_in,
  input  wire logic [7:0] tx_in,
  output logic            miso_out,
  output logic      [7:0] rx_out
);
  logic [8:0] sh_r = 9'h0AA;

  assign miso_out = sh_r[8];

  // with trailing-edge phase the first bit only appears at the first leading edge
  always @(posedge load_in) begin
    sh_r   = cpha_in ? {1'b0, tx_in} : {tx_in, 1'b0};
    rx_out = 8'h00;
  end

  // leading edge is any move away from the rest level
  always @(sclk_in) begin
    if ((sclk_in !== cpol_in) == !cpha_in) begin
      rx_out = {rx_out[6:0], mosi_in};
    end else begin
      sh_r = {sh_r[7:0], ~sh_r[0]};
    end
  end
endmodule // spc_slave_model

//--- verif/spc_port_tb_top.sv
// Purpose: self-checking bench for the serial port, master mode against a slave model
// Assumes: select held high during master frames; one closing slave frame is driven by the bench
// Notes:   register reads queue their expectation; a monitor checks each one at its ack
`timescale 1ns/1ps
module spc_port_tb_top;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0;
  logic [3:0]  wb_adr_in = 4'h0, wb_sel_in = 4'h0;
  logic [31:0] wb_dat_in = 32'h0, wb_dat_out;
  logic        wb_ack_out, sclk_out, sclk_oe_out, mosi_out, mosi_oe_out, miso_out, miso_oe_out, miso_w;
  logic        cpol = 1'b0, cpha = 1'b0, load = 1'b0;
  logic [7:0]  tx_b = 8'h00, sl_b = 8'h00, rx_w, cfg;
  logic [1:0]  ib;
  logic        ms_sclk = 1'b0, ms_mosi = 1'b0, ms_sel_n = 1'b1;
  logic [7:0]  mo_b, mi_b, pre_b;
  logic [31:0] exp_q[$];
  integer      fails = 0, compares = 0, seed = 99394, h;

  always #50 clk_in = ~clk_in;

  spc_port #(.HALF_BASE(spc_pkg::HALF_BASE)) spc_port_inst (.clk_in(clk_in), .rst_in(rst_in),
    .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
    .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
    .sclk_in(ms_sclk), .sclk_out(sclk_out), .sclk_oe_out(sclk_oe_out), .mosi_in(ms_mosi), .mosi_out(mosi_out),
    .mosi_oe_out(mosi_oe_out), .miso_in(miso_w), .miso_out(miso_out), .miso_oe_out(miso_oe_out),
    .sel_n_in(ms_sel_n));

  spc_slave_model spc_slave_model_inst (.sclk_in(sclk_out), .mosi_in(mosi_out), .cpol_in(cpol),
    .cpha_in(cpha), .load_in(load), .tx_in(sl_b), .miso_out(miso_w), .rx_out(rx_w));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // one classic cycle; request held until ack is sampled, then one idle cycle
  task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in  <= we;
    wb_adr_in <= a;
    wb_dat_in <= d;
    wb_sel_in <= 4'hF;
    do begin
      @(posedge clk_in);
      n++;
    end while (wb_ack_out !== 1'b1 && n < 20);
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    if (n >= 20) begin
      fails++;
      complete_run();
    end
    @(posedge clk_in);
  endtask

  // bench as far-end master for one slave frame: rest low, leading-edge sampling, eight-clock half period
  task automatic slave_frame(input logic [7:0] mo, output logic [7:0] mi);
    ms_sel_n <= 1'b0;
    repeat (8) @(posedge clk_in);
    check(32'({miso_oe_out, sclk_oe_out}), 32'h2);
    for (int b = 7; b >= 0; b--) begin
      ms_mosi <= mo[b];
      repeat (8) @(posedge clk_in);
      ms_sclk <= 1'b1;
      mi[b] = miso_out;
      repeat (8) @(posedge clk_in);
      ms_sclk <= 1'b0;
    end
    repeat (8) @(posedge clk_in);
    ms_sel_n <= 1'b1;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  always @(posedge clk_in) begin
    if (wb_ack_out === 1'b1 && wb_we_in === 1'b0)
      check(wb_dat_out, exp_q.pop_front());
  end

  initial begin
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    rd(spc_pkg::ADDR_CONTROL, 32'h0);
    rd(spc_pkg::ADDR_DATA, 32'h0);
    bus(1'b1, 4'hC, 32'h0000_00FF);
    rd(4'h8, 32'h0);
    rd(spc_pkg::ADDR_CONTROL, 32'h0);
    // every rate, both rest levels and both phases
    for (int i = 0; i < 4; i++) begin
      ib = i[1:0];
      cfg = {4'h1, ib[0], ib[1], ib};
      h = spc_pkg::HALF_BASE << ib;
      bus(1'b1, spc_pkg::ADDR_CONTROL, {24'h0, cfg});
      cpol <= cfg[3];
      cpha <= cfg[2];
      sl_b <= 8'($random(seed));
      tx_b <= 8'($random(seed));
      repeat (3) @(posedge clk_in);
      check(32'(sclk_out), 32'(cfg[3]));
      check(32'(sclk_oe_out), 32'h1);
      load <= 1'b1;
      @(posedge clk_in);
      load <= 1'b0;
      bus(1'b1, spc_pkg::ADDR_DATA, {24'h0, tx_b});
      bus(1'b1, spc_pkg::ADDR_DATA, {24'h0, ~tx_b});
      repeat (16 * h - 12) @(posedge clk_in);
      rd(spc_pkg::ADDR_CONTROL, {24'h0, cfg | 8'h40});
      repeat (20) @(posedge clk_in);
      rd(spc_pkg::ADDR_CONTROL, {24'h0, cfg | 8'hC0});
      rd(spc_pkg::ADDR_DATA, {24'h0, sl_b});
      check(32'(rx_w), 32'(tx_b));
      check(32'(sclk_out), 32'(cfg[3]));
      bus(1'b1, spc_pkg::ADDR_CONTROL, {24'h0, cfg});
      rd(spc_pkg::ADDR_CONTROL, {24'h0, cfg});
    end
    // disabled master must neither drive nor finish a transfer
    bus(1'b1, spc_pkg::ADDR_CONTROL, 32'h0000_0030);
    repeat (3) @(posedge clk_in);
    check(32'(sclk_oe_out), 32'h0);
    bus(1'b1, spc_pkg::ADDR_DATA, 32'h0000_005A);
    repeat (300) @(posedge clk_in);
    rd(spc_pkg::ADDR_CONTROL, 32'h0000_0030);
    bus(1'b1, spc_pkg::ADDR_CONTROL, 32'h0);
    repeat (5) @(posedge clk_in);
    check(32'({sclk_oe_out, mosi_oe_out, miso_oe_out}), 32'h0);
    // enabled slave: preload while deselected, then one frame from the bench master
    pre_b = 8'($random(seed));
    mo_b  = 8'($random(seed));
    bus(1'b1, spc_pkg::ADDR_DATA, {24'h0, pre_b});
    slave_frame(mo_b, mi_b);
    check(32'(mi_b), 32'(pre_b));
    rd(spc_pkg::ADDR_DATA, {24'h0, mo_b});
    rd(spc_pkg::ADDR_CONTROL, 32'h0000_0080);
    complete_run();
  end
endmodule // spc_port_tb_top
